// File: hdl/cssu_pkg.sv
// Purpose: shared constants and types for the condition store, string compare and shift unit
// Assumes: flags travel as a 4-bit vector {overflow, sign, zero, carry}
// Notes:   condition and size encodings are local to this core
package cssu_pkg;

  // ************************************************************
  // flag vector layout
  // ************************************************************
  localparam int FLAG_O = 3;
  localparam int FLAG_S = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;

  // ************************************************************
  // operand sizes and widths
  // ************************************************************
  localparam logic [1:0] SIZE_B = 2'h0;
  localparam logic [1:0] SIZE_W = 2'h1;
  localparam logic [1:0] SIZE_L = 2'h2;
  localparam int         PTR_W  = 24;
  localparam logic [7:0] MAX_SHIFT = 8'h21;
  localparam logic [PTR_W-1:0] STEP_BYTE = 24'h000001;
  localparam logic [PTR_W-1:0] STEP_WORD = 24'h000002;
  localparam logic [31:0] ADDR_MASK = 32'h00FFFFFF;

  // ************************************************************
  // condition codes for store_on_condition
  // ************************************************************
  localparam logic [3:0] CND_GEU = 4'h0;
  localparam logic [3:0] CND_LTU = 4'h1;
  localparam logic [3:0] CND_EQ  = 4'h2;
  localparam logic [3:0] CND_NE  = 4'h3;
  localparam logic [3:0] CND_GTU = 4'h4;
  localparam logic [3:0] CND_LEU = 4'h5;
  localparam logic [3:0] CND_PZ  = 4'h6;
  localparam logic [3:0] CND_N   = 4'h7;
  localparam logic [3:0] CND_GE  = 4'h8;
  localparam logic [3:0] CND_LT  = 4'h9;
  localparam logic [3:0] CND_GT  = 4'hA;
  localparam logic [3:0] CND_LE  = 4'hB;
  localparam logic [3:0] CND_O   = 4'hC;
  localparam logic [3:0] CND_NO  = 4'hD;

  // ************************************************************
  // operations and states
  // ************************************************************
  typedef enum logic [1:0] {
    OP_STORE_ON_CONDITION,
    OP_STRING_COMPARE_UNTIL_MISMATCH,
    OP_ARITH_SHIFT,
    OP_ARITH_SHIFT_NO_CARRY_OUT
  } cssu_op_type;

  typedef enum {
    ST_IDLE,
    ST_READ_FIRST,
    ST_READ_SECOND,
    ST_HOLD
  } cssu_state_type;

  typedef struct packed {
    logic [31:0] value;
    logic        carry;
    logic        ovf;
  } cssu_shift_res_type;

endpackage

// File: hdl/cssu_unit.sv
// Purpose: execution logic for store on condition, string compare and arithmetic shifts
// Assumes: one command at a time while cmdReady is high; memory answers byte reads
// Notes:   flags are returned with a per-flag write mask; masked flags keep the core's value
//
// Contract
// - store 1 when condition true, else 0
// - address register destination: upper eight bits zero
// - decode carry, zero and unsigned compare conditions
// - decode sign, overflow and signed compare conditions
// - byte compare: subtract, step by 1, stop
// - word compare: low first, high if equal, step 2
// - final pointer values are undefined
// - interrupt taken only after whole element
// - overflow on signed byte range, sign from MSB
// - zero on zero source or equal bytes
// - carry when unsigned subtraction has no borrow
// - positive count left, negative right, out bit carry
// - immediate counts: byte/word 8, long 32
// - register count up to 32, zero changes nothing
// - long shift to address register: 24-bit, flags undefined
// - overflow clear when out bits match result MSB
// - carry last out, sign MSB, zero all-zero
// - carry-free shift counts up to 32, signed direction
// - carry-free fill: zeros left, sign right
// - carry-free shift writes only sign and zero
`timescale 1ns/1ns

module cssu_unit
  import cssu_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // command
  input  wire logic              cmdValid,
  input  wire cssu_op_type       cmdOp,
  input  wire logic [1:0]        cmdSize,
  input  wire logic [3:0]        cmdCond,
  input  wire logic signed [7:0] cmdCount,
  input  wire logic [31:0]       cmdOperand,
  input  wire logic              cmdDestAddr,
  input  wire logic [PTR_W-1:0]  cmdFirstPtr,
  input  wire logic [PTR_W-1:0]  cmdSecondPtr,
  input  wire logic [3:0]        flagsIn,
  output logic                   cmdReady,
  // result
  output logic                   done,
  output logic [31:0]            result,
  output logic                   resultWe,
  output logic [3:0]             flagsOut,
  output logic [3:0]             flagsWe,
  // byte read path
  output logic                   memRdReq,
  output logic [PTR_W-1:0]       memRdAddr,
  input  wire logic [7:0]        memRdData,
  input  wire logic              memRdValid,
  // interrupt hand-off
  input  wire logic              irqReq,
  output logic                   irqAccept,
  // pointer registers
  output logic [PTR_W-1:0]       firstPtr,
  output logic [PTR_W-1:0]       secondPtr
);
  // ************************************************************
  // functions
  // ************************************************************
  function automatic int sizeWidth(input logic [1:0] sz);
    return (sz == SIZE_B) ? 8 : (sz == SIZE_W) ? 16 : 32;
  endfunction
  function automatic logic [31:0] sizeMask(input logic [1:0] sz);
    return 32'hFFFFFFFF >> (32 - sizeWidth(sz));
  endfunction
  function automatic logic condTrue(input logic [3:0] cnd, input logic [3:0] f);
    case (cnd)
      CND_GEU: return f[FLAG_C];
      CND_LTU: return ~f[FLAG_C];
      CND_EQ:  return f[FLAG_Z];
      CND_NE:  return ~f[FLAG_Z];
      CND_GTU: return f[FLAG_C] & ~f[FLAG_Z];
      CND_LEU: return ~(f[FLAG_C] & ~f[FLAG_Z]);
      CND_PZ:  return ~f[FLAG_S];
      CND_N:   return f[FLAG_S];
      CND_GE:  return ~(f[FLAG_S] ^ f[FLAG_O]);
      CND_LT:  return f[FLAG_S] ^ f[FLAG_O];
      CND_GT:  return ~((f[FLAG_S] ^ f[FLAG_O]) | f[FLAG_Z]);
      CND_LE:  return (f[FLAG_S] ^ f[FLAG_O]) | f[FLAG_Z];
      CND_O:   return f[FLAG_O];
      CND_NO:  return ~f[FLAG_O];
      default: return 1'b0;
    endcase
  endfunction
  // bit-serial model, stepped up to 33 times; counts past 32 are undefined
  function automatic cssu_shift_res_type shiftCalc(input logic [31:0] x, input logic [1:0] sz,
                                                   input logic signed [7:0] cnt);
    cssu_shift_res_type res;
    logic [31:0] v;
    logic [7:0]  n;
    logic        c, allOne, allZero;
    int          w;
    w = sizeWidth(sz);
    n = cnt[7] ? 8'(-cnt) : 8'(cnt);
    n = (n > MAX_SHIFT) ? MAX_SHIFT : n;
    c = 1'b0;
    allOne = 1'b1;
    allZero = 1'b1;
    res.ovf = 1'b0;
    if (!cnt[7]) begin
      v = x << (32 - w);
      for (int i = 0; i < 33; i++) begin
        if (i < int'(n)) begin
          c = v[31];
          allOne = allOne & c;
          allZero = allZero & ~c;
          v = {v[30:0], 1'b0};
        end
      end
      res.ovf = v[31] ? ~allOne : ~allZero;
      res.value = v >> (32 - w);
    end else begin
      v = x[w-1] ? (x | ~sizeMask(sz)) : (x & sizeMask(sz));
      for (int i = 0; i < 33; i++) begin
        if (i < int'(n)) begin
          c = v[0];
          v = {v[31], v[31:1]};
        end
      end
      res.value = v & sizeMask(sz);
    end
    res.carry = c;
    return res;
  endfunction
  // ************************************************************
  // state
  // ************************************************************
  cssu_state_type     state_reg,     state_next;
  logic [PTR_W-1:0]   firstPtr_reg,  firstPtr_next;
  logic [PTR_W-1:0]   secondPtr_reg, secondPtr_next;
  logic               isWord_reg,    isWord_next;
  logic               byteIdx_reg,   byteIdx_next;
  logic [7:0]         dataA_reg,     dataA_next;
  logic               memRdReq_reg,  memRdReq_next;
  logic [PTR_W-1:0]   memRdAddr_reg, memRdAddr_next;
  logic               done_reg,      done_next;
  logic [31:0]        result_reg,    result_next;
  logic               resultWe_reg,  resultWe_next;
  logic [3:0]         flagsOut_reg,  flagsOut_next;
  logic [3:0]         flagsWe_reg,   flagsWe_next;
  logic               irqAccept_reg, irqAccept_next;
  logic               ready_reg,     ready_next;
  cssu_shift_res_type shiftRes;
  logic [31:0]        shiftIn;
  logic [31:0]        shiftOut;
  logic [8:0]         diff;
  logic               cmpOvf;
  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    state_next     = state_reg;
    firstPtr_next  = firstPtr_reg;
    secondPtr_next = secondPtr_reg;
    isWord_next    = isWord_reg;
    byteIdx_next   = byteIdx_reg;
    dataA_next     = dataA_reg;
    memRdReq_next  = memRdReq_reg;
    memRdAddr_next = memRdAddr_reg;
    done_next      = 1'b0;
    result_next    = result_reg;
    resultWe_next  = 1'b0;
    flagsOut_next  = flagsOut_reg;
    flagsWe_next   = 4'h0;
    irqAccept_next = 1'b0;
    ready_next     = ready_reg;
    // address register operand zero-extended from 24 bits
    shiftIn   = cmdDestAddr ? (cmdOperand & ADDR_MASK) : cmdOperand;
    shiftRes  = shiftCalc(shiftIn, (cmdOp == OP_ARITH_SHIFT) ? cmdSize : SIZE_L, cmdCount);
    shiftOut  = cmdDestAddr ? (shiftRes.value & ADDR_MASK) : shiftRes.value;
    diff      = {1'b0, dataA_reg} - {1'b0, memRdData};
    cmpOvf    = (dataA_reg[7] != memRdData[7]) && (diff[7] != dataA_reg[7]);
    case (state_reg)
      ST_IDLE: begin
        if (cmdValid && ready_reg) begin
          done_next = (cmdOp != OP_STRING_COMPARE_UNTIL_MISMATCH);
          case (cmdOp)
            OP_STORE_ON_CONDITION: begin
              // 0 or 1, so upper address bits are zero too
              result_next   = condTrue(cmdCond, flagsIn) ? 32'h00000001 : 32'h00000000;
              resultWe_next = 1'b1;
              flagsWe_next  = 4'h0;
            end
            OP_STRING_COMPARE_UNTIL_MISMATCH: begin
              firstPtr_next  = cmdFirstPtr;
              secondPtr_next = cmdSecondPtr;
              isWord_next    = (cmdSize == SIZE_W);
              byteIdx_next   = 1'b0;
              memRdReq_next  = 1'b1;
              memRdAddr_next = cmdFirstPtr;
              ready_next     = 1'b0;
              state_next     = ST_READ_FIRST;
            end
            default: begin
              // zero count is a no-op; illegal immediates not trapped here
              if (cmdCount != 8'sh00) begin
                result_next   = shiftOut;
                resultWe_next = 1'b1;
                // shift result is already cut to the operand size
                flagsOut_next[FLAG_Z] = (shiftRes.value == 32'h00000000);
                if (cmdOp == OP_ARITH_SHIFT) begin
                  flagsOut_next[FLAG_S] = shiftRes.value[sizeWidth(cmdSize) - 1];
                  // carry and overflow from the bits shifted out
                  flagsOut_next[FLAG_C] = shiftRes.carry;
                  flagsOut_next[FLAG_O] = shiftRes.ovf;
                  // long into address register leaves flags alone
                  flagsWe_next = (cmdDestAddr && cmdSize == SIZE_L) ? 4'h0 : 4'hF;
                end else begin
                  flagsOut_next[FLAG_S] = shiftRes.value[31];
                  // sign and zero only, none for address register
                  flagsWe_next = cmdDestAddr ? 4'h0 : ((4'h1 << FLAG_S) | (4'h1 << FLAG_Z));
                end
              end
            end
          endcase
        end
      end
      ST_READ_FIRST: begin
        if (memRdValid) begin
          dataA_next     = memRdData;
          memRdAddr_next = secondPtr_reg + (byteIdx_reg ? STEP_BYTE : 24'h000000);
          state_next     = ST_READ_SECOND;
        end
      end
      ST_READ_SECOND: begin
        if (memRdValid) begin
          // overflow and sign of the byte difference
          flagsOut_next[FLAG_O] = cmpOvf;
          flagsOut_next[FLAG_S] = diff[7];
          flagsOut_next[FLAG_Z] = (dataA_reg == 8'h00) || (dataA_reg == memRdData);
          flagsOut_next[FLAG_C] = ~diff[8];
          if ((dataA_reg == 8'h00) || (dataA_reg != memRdData)) begin
            // stop on zero or mismatch; pointers left as they are
            memRdReq_next = 1'b0;
            flagsWe_next  = 4'hF;
            done_next     = 1'b1;
            ready_next    = 1'b1;
            state_next    = ST_IDLE;
          end else if (isWord_reg && !byteIdx_reg) begin
            // high byte only after a nonzero matching low byte
            byteIdx_next   = 1'b1;
            memRdAddr_next = firstPtr_reg + STEP_BYTE;
            state_next     = ST_READ_FIRST;
          end else begin
            // element finished, advance by its size
            byteIdx_next   = 1'b0;
            firstPtr_next  = firstPtr_reg + (isWord_reg ? STEP_WORD : STEP_BYTE);
            secondPtr_next = secondPtr_reg + (isWord_reg ? STEP_WORD : STEP_BYTE);
            memRdAddr_next = firstPtr_next;
            // interrupt only at an element boundary
            if (irqReq) begin
              memRdReq_next  = 1'b0;
              irqAccept_next = 1'b1;
              state_next     = ST_HOLD;
            end else begin
              state_next = ST_READ_FIRST;
            end
          end
        end
      end
      ST_HOLD: begin
        // resume once the interrupt request is withdrawn
        irqAccept_next = irqReq;
        if (!irqReq) begin
          memRdReq_next = 1'b1;
          state_next    = ST_READ_FIRST;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end
  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg     <= ST_IDLE;
      firstPtr_reg  <= 24'h000000;
      secondPtr_reg <= 24'h000000;
      isWord_reg    <= 1'b0;
      byteIdx_reg   <= 1'b0;
      dataA_reg     <= 8'h00;
      memRdReq_reg  <= 1'b0;
      memRdAddr_reg <= 24'h000000;
      done_reg      <= 1'b0;
      result_reg    <= 32'h00000000;
      resultWe_reg  <= 1'b0;
      flagsOut_reg  <= 4'h0;
      flagsWe_reg   <= 4'h0;
      irqAccept_reg <= 1'b0;
      ready_reg     <= 1'b1;
    end else begin
      state_reg     <= state_next;
      firstPtr_reg  <= firstPtr_next;
      secondPtr_reg <= secondPtr_next;
      isWord_reg    <= isWord_next;
      byteIdx_reg   <= byteIdx_next;
      dataA_reg     <= dataA_next;
      memRdReq_reg  <= memRdReq_next;
      memRdAddr_reg <= memRdAddr_next;
      done_reg      <= done_next;
      result_reg    <= result_next;
      resultWe_reg  <= resultWe_next;
      flagsOut_reg  <= flagsOut_next;
      flagsWe_reg   <= flagsWe_next;
      irqAccept_reg <= irqAccept_next;
      ready_reg     <= ready_next;
    end
  end

  assign cmdReady  = ready_reg;
  assign done      = done_reg;
  assign result    = result_reg;
  assign resultWe  = resultWe_reg;
  assign flagsOut  = flagsOut_reg;
  assign flagsWe   = flagsWe_reg;
  assign memRdReq  = memRdReq_reg;
  assign memRdAddr = memRdAddr_reg;
  assign irqAccept = irqAccept_reg;
  assign firstPtr  = firstPtr_reg;
  assign secondPtr = secondPtr_reg;
endmodule

// File: dv/cssu_mem_model.sv
// Purpose: byte memory standing behind the unit's read path
// Assumes: latency set by the bench; 0 answers on the same edge that first sees a request
// Notes:   between answers the data lines carry the inverse of the last byte
`timescale 1ns/1ns
module cssu_mem_model
  import cssu_pkg::*;
(
  // clock and reset
  input  logic             sys_clk,
  input  logic             sys_rst,
  // read path
  input  logic             memRdReq,
  input  logic [PTR_W-1:0] memRdAddr,
  output logic [7:0]       memRdData = 8'h00,
  output logic             memRdValid = 1'b0,
  // bench control
  input  int               lat,
  output int               nReads = 0
);
  logic [7:0] mem [0:255];
  int         waitCnt = 0;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h5A;
    end
  end

  // stale data is scrambled so a late sample cannot pass by luck
  always @(posedge sys_clk) begin
    if (sys_rst || memRdValid || !memRdReq) begin
      memRdValid <= 1'b0;
      waitCnt    <= 0;
      if (memRdValid) memRdData <= ~memRdData;
    end else if (waitCnt >= lat) begin
      memRdValid <= 1'b1;
      memRdData  <= mem[memRdAddr[7:0]];
      nReads     <= nReads + 1;
    end else begin
      waitCnt <= waitCnt + 1;
    end
  end
endmodule

// File: dv/cssu_checker.sv
// Purpose: port-level checks for the store, string compare and shift unit
// Assumes: flags travel as {O,S,Z,C}
// Notes:   single-cycle ops are judged on the cycle after they are taken
`timescale 1ns/1ns
module cssu_checker
  import cssu_pkg::*;
(
  // clock and reset
  input logic              sys_clk,
  input logic              sys_rst,
  // command
  input logic              cmdValid,
  input logic              cmdReady,
  input cssu_op_type       cmdOp,
  input logic [1:0]        cmdSize,
  input logic [3:0]        cmdCond,
  input logic signed [7:0] cmdCount,
  input logic              cmdDestAddr,
  input logic [PTR_W-1:0]  cmdFirstPtr,
  input logic [3:0]        flagsIn,
  // result
  input logic              done,
  input logic [31:0]       result,
  input logic              resultWe,
  input logic [3:0]        flagsOut,
  input logic [3:0]        flagsWe,
  // read path and interrupt
  input logic              memRdReq,
  input logic [PTR_W-1:0]  memRdAddr,
  input logic              memRdValid,
  input logic              irqAccept
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic       take;
  logic       shTake;
  logic       stTake;
  logic [3:0] flagsPrev;
  assign take   = cmdValid && cmdReady;
  assign stTake = take && cmdOp == OP_STORE_ON_CONDITION;
  // both shift ops have bit 1 of the op set
  assign shTake = take && cmdOp[1] && cmdCount != 8'sh00;
  always_ff @(posedge sys_clk) flagsPrev <= flagsIn;

  // ************************************************************
  // assertions
  // ************************************************************
  a_quick_done: assert property (take && cmdOp != OP_STRING_COMPARE_UNTIL_MISMATCH |=> done)
    else $error("store or shift late");
  a_store_flags: assert property (stTake |=> resultWe && flagsWe == 4'h0 && result[31:1] == 31'h0)
    else $error("store touched flags or upper bits");
  a_store_equal: assert property (stTake && cmdCond == CND_EQ |=> result[0] == flagsPrev[FLAG_Z])
    else $error("equal condition wrong");
  a_store_less: assert property (stTake && cmdCond == CND_LT
    |=> result[0] == (flagsPrev[FLAG_S] ^ flagsPrev[FLAG_O])) else $error("signed less wrong");
  a_zero_count: assert property (take && cmdOp[1] && cmdCount == 8'sh00
    |=> done && !resultWe && flagsWe == 4'h0) else $error("zero count changed state");
  a_nc_mask: assert property (shTake && cmdOp == OP_ARITH_SHIFT_NO_CARRY_OUT && !cmdDestAddr
    |=> flagsWe == 4'h6) else $error("carry-free flag mask wrong");
  a_long_addr: assert property (shTake && cmdOp == OP_ARITH_SHIFT && cmdSize == SIZE_L && cmdDestAddr
    |=> flagsWe == 4'h0 && result[31:24] == 8'h00) else $error("address shift wrong");
  a_long_flags: assert property (shTake && cmdOp == OP_ARITH_SHIFT && cmdSize == SIZE_L && !cmdDestAddr
    |=> flagsWe == 4'hF && flagsOut[FLAG_S] == result[31] && flagsOut[FLAG_Z] == (result == 32'h0))
    else $error("long shift flags wrong");
  a_cmp_start: assert property (take && cmdOp == OP_STRING_COMPARE_UNTIL_MISMATCH
    |=> memRdReq && !cmdReady && memRdAddr == $past(cmdFirstPtr)) else $error("compare start wrong");
  a_rd_hold: assert property (memRdReq && !memRdValid |=> memRdReq && $stable(memRdAddr))
    else $error("read dropped early");
  a_irq_park: assert property (irqAccept |-> !memRdReq && !cmdReady)
    else $error("read during interrupt");
  c_cmp: cover property (take && cmdOp == OP_STRING_COMPARE_UNTIL_MISMATCH);
  c_irq: cover property ($rose(irqAccept));
  c_zero: cover property (take && cmdOp[1] && cmdCount == 8'sh00);
endmodule

bind cssu_unit cssu_checker u_chk (.*);

// File: dv/cssu_unit_tb.sv
// Purpose: self-checking bench for cssu_unit
// Assumes: memory model answers byte reads after a bench-set latency
// Notes:   a loop covers stores, rows cover shifts; compares, interrupt and reset follow by hand
`timescale 1ns/1ns
module cssu_unit_tb
  import cssu_pkg::*;
;
  localparam cssu_op_type ST = OP_STORE_ON_CONDITION;
  localparam cssu_op_type SC = OP_STRING_COMPARE_UNTIL_MISMATCH;
  localparam cssu_op_type SH = OP_ARITH_SHIFT;
  localparam cssu_op_type NC = OP_ARITH_SHIFT_NO_CARRY_OUT;
  typedef struct {
    cssu_op_type op; logic [1:0] sz; logic signed [7:0] cnt; logic [31:0] opd; logic dst;
    logic [31:0] res; logic we; logic [3:0] fwe; logic [3:0] fo;
  } cssu_row_type;
  logic              sys_clk      = 1'b0;
  logic              sys_rst      = 1'b1;
  logic              cmdValid     = 1'b0;
  cssu_op_type       cmdOp        = ST;
  logic [1:0]        cmdSize      = 2'h0;
  logic [3:0]        cmdCond      = 4'h0;
  logic signed [7:0] cmdCount     = 8'sh00;
  logic [31:0]       cmdOperand   = 32'h0;
  logic              cmdDestAddr  = 1'b0;
  logic [PTR_W-1:0]  cmdFirstPtr  = 24'h0;
  logic [PTR_W-1:0]  cmdSecondPtr = 24'h0;
  logic [3:0]        flagsIn      = 4'h0;
  logic              irqReq       = 1'b0;
  logic              cmdReady, done, resultWe, memRdReq, memRdValid, irqAccept;
  logic [31:0]       result;
  logic [3:0]        flagsOut, flagsWe;
  logic [7:0]        memRdData;
  logic [PTR_W-1:0]  memRdAddr, firstPtr, secondPtr;
  int                n_mismatch = 0;
  int                n_compared = 0;
  int                cyc        = 0;
  int                lat        = 0;
  int                nReads;
  cssu_row_type      rows [13] = '{
    '{SH, SIZE_B, 8'sh01, 32'h81, 1'b0, 32'h02, 1'b1, 4'hF, 4'h9},
    '{SH, SIZE_B, -8'sh01, 32'h81, 1'b0, 32'hC0, 1'b1, 4'hF, 4'h5},
    '{SH, SIZE_B, 8'sh08, 32'h01, 1'b0, 32'h00, 1'b1, 4'hF, 4'hB},
    '{SH, SIZE_W, -8'sh08, 32'h80FF, 1'b0, 32'hFF80, 1'b1, 4'hF, 4'h5},
    '{SH, SIZE_W, 8'sh01, 32'h4000, 1'b0, 32'h8000, 1'b1, 4'hF, 4'hC},
    '{SH, SIZE_L, 8'sh20, 32'h1, 1'b0, 32'h0, 1'b1, 4'hF, 4'hB},
    '{SH, SIZE_L, -8'sh20, 32'hFFFFFFFF, 1'b0, 32'hFFFFFFFF, 1'b1, 4'hF, 4'h5},
    '{SH, SIZE_L, 8'sh04, 32'h40000000, 1'b0, 32'h0, 1'b1, 4'hF, 4'hA},
    '{SH, SIZE_L, 8'sh00, 32'h1234, 1'b0, 32'h0, 1'b0, 4'h0, 4'h0},
    '{SH, SIZE_L, 8'sh01, 32'hFF800001, 1'b1, 32'h2, 1'b1, 4'h0, 4'h0},
    '{NC, SIZE_L, -8'sh04, 32'h80000010, 1'b0, 32'hF8000001, 1'b1, 4'h6, 4'h4},
    '{NC, SIZE_L, 8'sh04, 32'h80000001, 1'b0, 32'h10, 1'b1, 4'h6, 4'h0},
    '{NC, SIZE_L, -8'sh01, 32'hFF800000, 1'b1, 32'h00400000, 1'b1, 4'h0, 4'h0}
  };

  cssu_unit u_dut (.sys_clk, .sys_rst, .cmdValid, .cmdOp, .cmdSize, .cmdCond, .cmdCount, .cmdOperand,
    .cmdDestAddr, .cmdFirstPtr, .cmdSecondPtr, .flagsIn, .cmdReady, .done, .result, .resultWe, .flagsOut,
    .flagsWe, .memRdReq, .memRdAddr, .memRdData, .memRdValid, .irqReq, .irqAccept, .firstPtr, .secondPtr);
  cssu_mem_model u_mem (.sys_clk, .sys_rst, .memRdReq, .memRdAddr, .memRdData, .memRdValid, .lat, .nReads);

  always #5 sys_clk = ~sys_clk;

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chkv(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // compare pointers ride on the operand: second string sits 16 bytes above the first
  task automatic start(cssu_op_type op, logic [1:0] sz, logic [3:0] cnd, logic signed [7:0] cnt,
                       logic [31:0] opd, logic dst, logic [3:0] fin);
    @(posedge sys_clk);
    cmdValid     <= 1'b1;
    cmdOp        <= op;
    cmdSize      <= sz;
    cmdCond      <= cnd;
    cmdCount     <= cnt;
    cmdOperand   <= opd;
    cmdDestAddr  <= dst;
    flagsIn      <= fin;
    cmdFirstPtr  <= opd[23:0];
    cmdSecondPtr <= opd[23:0] + 24'h10;
    @(posedge sys_clk);
    cmdValid     <= 1'b0;
  endtask

  // done stands one cycle right after the taking edge, so look before waiting
  task automatic waitDone();
    int k;
    k = 0;
    #1;
    while (done !== 1'b1 && k < 400) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chkv("done", 32'h1, 32'(done));
  endtask

  task automatic put(logic [7:0] a, logic [31:0] w);
    for (int i = 0; i < 4; i++) begin
      u_mem.mem[a + i] = w[31 - 8 * i -: 8];
    end
  endtask

  task automatic strCmp(logic [7:0] a, logic [1:0] sz, logic [3:0] fo, int reads, logic irq);
    int n0;
    int k;
    n0 = nReads;
    k  = 0;
    if (irq) begin
      @(posedge sys_clk);
      irqReq <= 1'b1;
    end
    start(SC, sz, 4'h0, 8'sh00, 32'(a), 1'b0, 4'h0);
    if (irq) begin
      while (irqAccept !== 1'b1 && k < 50) begin
        @(posedge sys_clk);
        #1;
        k++;
      end
      chkv("irqAccept", 32'h1, 32'(irqAccept));
      chkv("irqReads", 32'h2, 32'(nReads - n0));
      chkv("firstPtr", 32'(a) + 32'h1, 32'(firstPtr));
      chkv("secondPtr", 32'(a) + 32'h11, 32'(secondPtr));
      repeat (3) @(posedge sys_clk);
      irqReq <= 1'b0;
    end
    waitDone();
    chkv("cmpFlags", 32'(fo), 32'(flagsOut));
    chkv("cmpFlagsWe", 32'hF, 32'(flagsWe));
    chkv("cmpReads", 32'(reads), 32'(nReads - n0));
  endtask

  function automatic logic condRef(logic [3:0] c, logic [3:0] f);
    logic lt;
    lt = f[FLAG_S] ^ f[FLAG_O];
    case (c)
      CND_GEU: return f[FLAG_C];
      CND_LTU: return !f[FLAG_C];
      CND_EQ:  return f[FLAG_Z];
      CND_NE:  return !f[FLAG_Z];
      CND_GTU: return f[FLAG_C] && !f[FLAG_Z];
      CND_LEU: return !(f[FLAG_C] && !f[FLAG_Z]);
      CND_PZ:  return !f[FLAG_S];
      CND_N:   return f[FLAG_S];
      CND_GE:  return !lt;
      CND_LT:  return lt;
      CND_GT:  return !(lt || f[FLAG_Z]);
      CND_LE:  return lt || f[FLAG_Z];
      CND_O:   return f[FLAG_O];
      default: return !f[FLAG_O];
    endcase
  endfunction

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [31:0] m;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    chkv("readyAtReset", 32'h1, 32'(cmdReady));
    chkv("resultAtReset", 32'h0, result);
    for (int c = 0; c < 14; c++) begin
      for (int f = 0; f < 16; f++) begin
        start(ST, SIZE_B, 4'(c), 8'sh00, 32'h0, c[0], 4'(f));
        waitDone();
        chkv("store", 32'(condRef(4'(c), 4'(f))), result);
        chkv("storeFlagsWe", 32'h0, 32'(flagsWe));
      end
    end
    foreach (rows[i]) begin
      start(rows[i].op, rows[i].sz, 4'h0, rows[i].cnt, rows[i].opd, rows[i].dst, 4'hF);
      waitDone();
      m = rows[i].op != SH || rows[i].sz == SIZE_L ? 32'hFFFFFFFF : rows[i].sz == SIZE_B ? 32'hFF : 32'hFFFF;
      if (rows[i].we) chkv("result", rows[i].res & m, result & m);
      chkv("resultWe", 32'(rows[i].we), 32'(resultWe));
      chkv("flagsWe", 32'(rows[i].fwe), 32'(flagsWe));
      chkv("flags", 32'(rows[i].fo), 32'(flagsOut & flagsWe));
    end
    put(8'h00, 32'h41420000);
    put(8'h10, 32'h41420000);
    put(8'h20, 32'h41800000);
    put(8'h30, 32'h41010000);
    put(8'h40, 32'h11221020);
    put(8'h50, 32'h11221030);
    put(8'h60, 32'h05090000);
    put(8'h70, 32'h03090000);
    put(8'h80, 32'h41000000);
    put(8'h90, 32'h41000000);
    strCmp(8'h00, SIZE_B, 4'h3, 6, 1'b0);
    lat = 3;
    strCmp(8'h20, SIZE_B, 4'h9, 4, 1'b0);
    strCmp(8'h40, SIZE_W, 4'h4, 8, 1'b0);
    lat = 0;
    strCmp(8'h60, SIZE_W, 4'h1, 2, 1'b0);
    strCmp(8'h80, SIZE_W, 4'h3, 4, 1'b0);
    lat = 2;
    strCmp(8'h00, SIZE_B, 4'h3, 6, 1'b1);
    // reset in mid compare must leave the unit idle
    start(SC, SIZE_B, 4'h0, 8'sh00, 32'h0, 1'b0, 4'h0);
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chkv("readyAfterReset", 32'h1, 32'(cmdReady));
    chkv("reqAfterReset", 32'h0, 32'(memRdReq));
    strCmp(8'h20, SIZE_B, 4'h9, 4, 1'b0);
    give_verdict();
  end
endmodule
